// ---- hw/gcb_bank.v ----
// gcb_bank.v: global configuration control register bank.
// assumes an index/data access port already decoded by the host bus front end;
// rst is the host bus reset, straps are stable while rst is high.
// Function
// R1: read/write logical device number register at index 07h selects visible device.
// R2: first trigger type register resets to FFh, all level.
// R3: first trigger bits 5,3,2,1,0: serial, keyboard, mouse, IR, IR wake; 1 level.
// R4: second trigger bits 7,6,1: monitor, watchdog, system management; others reserved.
// R5: sixteen polarity bits in two registers, 1 active low, reset 00h.
// R6: host sets option bit 4 before touching trigger or polarity registers.
// R7: pin function bits 3:2 pick pin role; test strap forces reserved.
// R8: strap-derived bits read back the sampled strap level.
// R9: host may overwrite strap-derived bits by ordinary writes.
// R10: host leaves reserved registers at their default values.
// R11: two-byte read-only chip ID; low byte steps per revision.
// R12: host enters configuration with 87h twice at the strap-chosen port.
// R13: with option bit 4 clear, trigger and polarity writes are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "gcb_consts.vh"

module gcb_bank #(
    parameter [7:0] CHIP_ID_HI = 8'hA5, // arbitrary value
    parameter [7:0] CHIP_ID_LO = 8'h11  // arbitrary value, revision counts up
) (
    // clock and host bus reset
    input  wire        clk,
    input  wire        rst,
    // register access port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_idx,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // straps
    input  wire        config_port_select_strap,
    input  wire        factory_test_strap,
    // configuration outputs
    output wire [7:0]  logical_device_select,
    output wire [7:0]  irq_level_sel_a,
    output wire [7:0]  irq_level_sel_b,
    output wire [15:0] irq_active_low,
    output wire        config_port_select,
    output reg  [1:0]  pin_role
);

    reg [7:0] ldev_q;
    reg [7:0] trig_a_q;
    reg [7:0] trig_b_q;
    reg [7:0] pol_hi_q;
    reg [7:0] pol_lo_q;
    reg [7:0] pinfn_q;
    reg [7:0] opt26_q;
    reg       strap_done_q;
    reg [7:0] rdata_d;
    wire [1:0] role_d;
    wire      unlocked;
    wire      strap_catch;
    wire      cfg_wr;
    wire      wr_ldev;
    wire      wr_pinfn;
    wire      wr_opt26;
    wire      wr_trig_a;
    wire      wr_trig_b;
    wire      wr_pol_hi;
    wire      wr_pol_lo;

    // merge masked write data with the stored value
    function [7:0] masked;
        input [7:0] old_v;
        input [7:0] new_v;
        input [7:0] mask;
        begin
            masked = (new_v & mask) | (old_v & ~mask);
        end
    endfunction

    // true when a qualified write strobe addresses the given index
    function wr_hit;
        input       strobe;
        input [7:0] idx;
        input [7:0] target;
        begin
            wr_hit = strobe && (idx == target);
        end
    endfunction

    assign unlocked    = opt26_q[`GCB_BIT_OPT_UNLOCK];
    assign strap_catch = !rst && !strap_done_q;
    assign cfg_wr      = reg_wr && unlocked; // [R13]

    // write enables, one per writable index; interrupt setup needs the unlock
    assign wr_ldev   = wr_hit(reg_wr, reg_idx, `GCB_IDX_LDEV);
    assign wr_pinfn  = wr_hit(reg_wr, reg_idx, `GCB_IDX_PINFN_A);
    assign wr_opt26  = wr_hit(reg_wr, reg_idx, `GCB_IDX_OPT26);
    assign wr_trig_a = wr_hit(cfg_wr, reg_idx, `GCB_IDX_TRIG_A); // [R13]
    assign wr_trig_b = wr_hit(cfg_wr, reg_idx, `GCB_IDX_TRIG_B); // [R13]
    assign wr_pol_hi = wr_hit(cfg_wr, reg_idx, `GCB_IDX_POL_HI); // [R13]
    assign wr_pol_lo = wr_hit(cfg_wr, reg_idx, `GCB_IDX_POL_LO); // [R13]

    // strap capture pending flag, rearmed by every reset
    always @(posedge clk) begin
        if (rst) begin
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    // global option register: writable; strap caught in the first cycle after release unless a write lands then
    always @(posedge clk) begin
        if (rst) begin
            opt26_q <= `GCB_RST_OPT26;
        end else if (wr_opt26) begin
            opt26_q <= masked(opt26_q, reg_wdata, `GCB_MASK_OPT26); // [R9]
        end else if (strap_catch) begin
            opt26_q[`GCB_BIT_OPT_PORTSEL] <= config_port_select_strap; // [R8]
        end
    end

    // logical device number, all bits writable
    always @(posedge clk) begin
        if (rst) begin
            ldev_q <= `GCB_RST_LDEV;
        end else if (wr_ldev) begin
            ldev_q <= reg_wdata; // [R1]
        end
    end

    // pin function field; reserved bits keep their value
    always @(posedge clk) begin
        if (rst) begin
            pinfn_q <= `GCB_RST_PINFN;
        end else if (wr_pinfn) begin
            pinfn_q <= masked(pinfn_q, reg_wdata, `GCB_MASK_PINFN); // [R7]
        end
    end

    // first trigger type register, level after reset
    always @(posedge clk) begin
        if (rst) begin
            trig_a_q <= `GCB_RST_TRIG; // [R2]
        end else if (wr_trig_a) begin
            trig_a_q <= masked(trig_a_q, reg_wdata, `GCB_MASK_TRIG_A); // [R3]
        end
    end

    // second trigger type register, reserved bits untouched
    always @(posedge clk) begin
        if (rst) begin
            trig_b_q <= `GCB_RST_TRIG;
        end else if (wr_trig_b) begin
            trig_b_q <= masked(trig_b_q, reg_wdata, `GCB_MASK_TRIG_B); // [R4]
        end
    end

    // polarity of channels 15 to 8
    always @(posedge clk) begin
        if (rst) begin
            pol_hi_q <= `GCB_RST_POL; // [R5]
        end else if (wr_pol_hi) begin
            pol_hi_q <= reg_wdata; // [R5]
        end
    end

    // polarity of channels 7 to 0
    always @(posedge clk) begin
        if (rst) begin
            pol_lo_q <= `GCB_RST_POL; // [R5]
        end else if (wr_pol_lo) begin
            pol_lo_q <= reg_wdata; // [R5]
        end
    end

    // read decode; reserved bits and unmapped indexes read zero
    always @* begin
        case (reg_idx)
            `GCB_IDX_LDEV:    rdata_d = ldev_q;
            `GCB_IDX_TRIG_A:  rdata_d = trig_a_q & `GCB_MASK_TRIG_A;
            `GCB_IDX_TRIG_B:  rdata_d = trig_b_q & `GCB_MASK_TRIG_B;
            `GCB_IDX_POL_HI:  rdata_d = pol_hi_q;
            `GCB_IDX_POL_LO:  rdata_d = pol_lo_q;
            `GCB_IDX_PINFN_A: rdata_d = pinfn_q;
            `GCB_IDX_ID_HI:   rdata_d = CHIP_ID_HI; // [R11]
            `GCB_IDX_ID_LO:   rdata_d = CHIP_ID_LO; // [R11]
            `GCB_IDX_OPT26:   rdata_d = opt26_q; // [R8]
            default:          rdata_d = `GCB_RDATA_UNMAPPED;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata  <= `GCB_RST_RDATA;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_d;
            end
        end
    end

    // pin role decode, registered for the output
    gcb_pin_mux u_mux (
        .factory_test_strap (factory_test_strap),
        .sel                (pinfn_q[`GCB_PINFN_MSB:`GCB_PINFN_LSB]),
        .role               (role_d)
    );

    always @(posedge clk) begin
        if (rst) begin
            pin_role <= `GCB_ROLE_MONCLK;
        end else begin
            pin_role <= role_d; // [R7]
        end
    end

    // configuration outputs straight from the registers
    assign logical_device_select = ldev_q;
    assign irq_level_sel_a       = trig_a_q & `GCB_MASK_TRIG_A;
    assign irq_level_sel_b       = trig_b_q & `GCB_MASK_TRIG_B;
    assign irq_active_low        = {pol_hi_q, pol_lo_q};
    assign config_port_select    = opt26_q[`GCB_BIT_OPT_PORTSEL];

endmodule
`default_nettype wire

// ---- hw/gcb_consts.vh ----
// gcb_consts.vh: constants of the global configuration control bank.
// assumes inclusion by both design files; definitions only.
`ifndef GCB_CONSTS_VH
`define GCB_CONSTS_VH

// register indexes
`define GCB_IDX_LDEV        8'h07
`define GCB_IDX_TRIG_A      8'h10
`define GCB_IDX_TRIG_B      8'h11
`define GCB_IDX_POL_HI      8'h13
`define GCB_IDX_POL_LO      8'h14
`define GCB_IDX_PINFN_A     8'h1A
`define GCB_IDX_ID_HI       8'h20
`define GCB_IDX_ID_LO       8'h21
`define GCB_IDX_OPT26       8'h26

// reset values
`define GCB_RST_LDEV        8'h00
`define GCB_RST_TRIG        8'hFF
`define GCB_RST_POL         8'h00
`define GCB_RST_PINFN       8'h00
`define GCB_RST_OPT26       8'h00
`define GCB_RST_RDATA       8'h00

// read value of unmapped indexes
`define GCB_RDATA_UNMAPPED  8'h00

// writable bit masks; reserved bits read as zero
`define GCB_MASK_TRIG_A     8'h2F
`define GCB_MASK_TRIG_B     8'hC2
`define GCB_MASK_PINFN      8'h0C
`define GCB_MASK_OPT26      8'h73

// field positions
`define GCB_BIT_OPT_UNLOCK  4
`define GCB_BIT_OPT_PORTSEL 6
`define GCB_PINFN_LSB       2
`define GCB_PINFN_MSB       3

// pin role codes
`define GCB_ROLE_MONCLK     2'h0
`define GCB_ROLE_SMBCLK     2'h1
`define GCB_ROLE_GPIO41     2'h2
`define GCB_ROLE_RESERVED   2'h3

`endif

// ---- hw/gcb_pin_mux.v ----
// gcb_pin_mux.v: decodes the pin function field into a pin role.
// assumes a registered select field and a sampled test strap.
`timescale 1ns/100ps
`default_nettype none
`include "gcb_consts.vh"

module gcb_pin_mux (
    // control
    input  wire       factory_test_strap,
    input  wire [1:0] sel,
    // result
    output reg  [1:0] role
);

    // test strap overrides the select field; 11 aliases monitor clock
    always @* begin
        if (factory_test_strap) begin
            role = `GCB_ROLE_RESERVED; // [R7]
        end else begin
            case (sel)
                2'h1:    role = `GCB_ROLE_SMBCLK; // [R7]
                2'h2:    role = `GCB_ROLE_GPIO41; // [R7]
                default: role = `GCB_ROLE_MONCLK; // [R7]
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- tb/gcb_host_model.sv ----
// gcb_host_model.sv: host bus controller issuing index/data register accesses.
// assumes the bank samples strobes on rising clk; this model drives at falling clk.
`timescale 1ns/100ps
`default_nettype none
module gcb_host_model (
    // clock and read return
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    // access strobes
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_idx,
    output var  logic [7:0] reg_wdata
);
    // idle bus at time zero
    initial {reg_wr, reg_rd, reg_idx, reg_wdata} = 18'h0;
    // one write, data inverted once released; reserved indexes never used
    task automatic wr(input logic [7:0] i, input logic [7:0] wd);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_idx = i;
        reg_wdata = wd;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~wd;
    endtask
    // one read, answer taken in the cycle it stands
    task automatic rd(input logic [7:0] i, output logic [7:0] rdat, output logic ok);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_idx = i;
        @(negedge clk);
        reg_rd = 1'b0;
        rdat = reg_rdata;
        ok = reg_rvalid;
    endtask
endmodule
`default_nettype wire

// ---- tb/gcb_bank_asserts.sv ----
// gcb_bank_asserts.sv: port timing checks for the configuration bank.
// assumes binding into every gcb_bank; rst is synchronous, active high.
`timescale 1ns/100ps
`default_nettype none
module gcb_bank_asserts #(
    parameter [7:0] CHIP_ID_LO = 8'h11
) (
    // clock, reset and access port
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_rvalid,
    input wire logic [7:0]  reg_idx,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // straps
    input wire logic        config_port_select_strap,
    input wire logic        factory_test_strap,
    // configuration outputs
    input wire logic [7:0]  logical_device_select,
    input wire logic [7:0]  irq_level_sel_a,
    input wire logic [7:0]  irq_level_sel_b,
    input wire logic [15:0] irq_active_low,
    input wire logic        config_port_select,
    input wire logic [1:0]  pin_role
);
    logic unl_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // mirror of the unlock bit, tracked from host writes
    always_ff @(posedge clk) unl_q <= rst ? 1'b0 : ((reg_wr && reg_idx == 8'h26) ? reg_wdata[4] : unl_q);
    // register relations
    property p_ldev; reg_wr && reg_idx == 8'h07 |=> logical_device_select == $past(reg_wdata); endproperty
    a_ldev: assert property (p_ldev) else $error("ldev write lost");
    property p_lock; reg_wr && reg_idx == 8'h10 && !unl_q |=> $stable(irq_level_sel_a); endproperty
    a_lock: assert property (p_lock) else $error("locked write taken");
    property p_tra; reg_wr && reg_idx == 8'h10 && unl_q |=> irq_level_sel_a == ($past(reg_wdata) & 8'h2F); endproperty
    a_tra: assert property (p_tra) else $error("trigger a wrong");
    property p_trb; reg_wr && reg_idx == 8'h11 && unl_q |=> irq_level_sel_b == ($past(reg_wdata) & 8'hC2); endproperty
    a_trb: assert property (p_trb) else $error("trigger b wrong");
    property p_rst; $fell(rst) |-> irq_level_sel_a == 8'h2F && irq_active_low == 16'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    property p_strap; $fell(rst) && !(reg_wr && reg_idx == 8'h26) |=> config_port_select == $past(config_port_select_strap); endproperty
    a_strap: assert property (p_strap) else $error("strap not sampled");
    property p_test; factory_test_strap |=> pin_role == 2'h3; endproperty
    a_test: assert property (p_test) else $error("test strap ignored");
    property p_id; reg_rd && reg_idx == 8'h21 |=> reg_rvalid && reg_rdata == CHIP_ID_LO; endproperty
    a_id: assert property (p_id) else $error("chip id wrong");
endmodule
bind gcb_bank gcb_bank_asserts #(.CHIP_ID_LO(CHIP_ID_LO)) u_chk (
    .clk                      (clk),
    .rst                      (rst),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rvalid               (reg_rvalid),
    .reg_idx                  (reg_idx),
    .reg_wdata                (reg_wdata),
    .reg_rdata                (reg_rdata),
    .config_port_select_strap (config_port_select_strap),
    .factory_test_strap       (factory_test_strap),
    .logical_device_select    (logical_device_select),
    .irq_level_sel_a          (irq_level_sel_a),
    .irq_level_sel_b          (irq_level_sel_b),
    .irq_active_low           (irq_active_low),
    .config_port_select       (config_port_select),
    .pin_role                 (pin_role)
);
`default_nettype wire

// ---- tb/tb_top.sv ----
// tb_top.sv: self-checking bench for the global configuration bank.
// assumes gcb_host_model as host and the bound checker beside the bank.
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
    logic clk = 1'b0, rst = 1'b1, config_port_select_strap = 1'b1, factory_test_strap = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, config_port_select, v;
    logic [7:0] reg_idx, reg_wdata, reg_rdata, logical_device_select, d;
    logic [7:0] irq_level_sel_a, irq_level_sel_b;
    logic [15:0] irq_active_low;
    logic [1:0] pin_role;
    int n_mismatch = 0, total_checks = 0;
    // clock, host and bank; id value is arbitrary
    always #5 clk = ~clk;
    gcb_host_model host (
        .clk        (clk),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_idx    (reg_idx),
        .reg_wdata  (reg_wdata)
    );
    gcb_bank #(
        .CHIP_ID_HI (8'hA5),
        .CHIP_ID_LO (8'h11)
    ) dut (
        .clk                      (clk),
        .rst                      (rst),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_idx                  (reg_idx),
        .reg_wdata                (reg_wdata),
        .reg_rdata                (reg_rdata),
        .reg_rvalid               (reg_rvalid),
        .config_port_select_strap (config_port_select_strap),
        .factory_test_strap       (factory_test_strap),
        .logical_device_select    (logical_device_select),
        .irq_level_sel_a          (irq_level_sel_a),
        .irq_level_sel_b          (irq_level_sel_b),
        .irq_active_low           (irq_active_low),
        .config_port_select       (config_port_select),
        .pin_role                 (pin_role)
    );
    // read one index and compare
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        host.rd(i, d, v);
        `CK("rvalid", 1'b1, v)
        `CK("rdata", e, d)
    endtask
    // reset values, strap read-back and read-only id
    task automatic t_reset;
        @(negedge clk);
        `CK("port_sel", 1'b1, config_port_select)
        rdc(8'h07, 8'h00);
        rdc(8'h1A, 8'h00);
        rdc(8'h20, 8'hA5);
        rdc(8'h10, 8'h2F);
        rdc(8'h11, 8'hC2);
        rdc(8'h14, 8'h00);
        rdc(8'h26, 8'h40);
        host.wr(8'h21, 8'h00);
        rdc(8'h21, 8'h11);
    endtask
    // locked writes ignored, then unlocked writes land masked
    task automatic t_lock;
        host.wr(8'h10, 8'h00);
        host.wr(8'h14, 8'hFF);
        `CK("locked", 24'h2F0000, {irq_level_sel_a, irq_active_low})
        host.wr(8'h26, 8'h10);
        `CK("port_sel", 1'b0, config_port_select)
        host.wr(8'h10, 8'hD5);
        host.wr(8'h11, 8'h7F);
        host.wr(8'h13, 8'hA5);
        host.wr(8'h14, 8'h3C);
        `CK("trig_a", 8'h05, irq_level_sel_a)
        `CK("trig_b", 8'h42, irq_level_sel_b)
        `CK("polarity", 16'hA53C, irq_active_low)
        rdc(8'h13, 8'hA5);
        host.wr(8'h07, 8'h5A);
        `CK("ldev", 8'h5A, logical_device_select)
    endtask
    // every pin function select code, then the test strap override
    task automatic t_pin;
        for (int s = 0; s < 4; s++) begin
            host.wr(8'h1A, 8'(s << 2));
            @(negedge clk);
            `CK("pin_role", (s == 3) ? 2'h0 : 2'(s), pin_role)
        end
        factory_test_strap = 1'b1;
        @(negedge clk);
        `CK("pin_test", 2'h3, pin_role)
    endtask
    // mid-run reset restores defaults, relocks and samples the strap again
    task automatic t_rerst;
        @(negedge clk);
        rst = 1'b1;
        config_port_select_strap = 1'b0;
        factory_test_strap = 1'b0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        `CK("port_sel", 1'b0, config_port_select)
        `CK("pol_rst", 16'h0000, irq_active_low)
        `CK("trig_b_rst", 8'hC2, irq_level_sel_b)
        `CK("ldev_rst", 8'h00, logical_device_select)
        `CK("pin_rst", 2'h0, pin_role)
        rdc(8'h10, 8'h2F);
        rdc(8'h26, 8'h00);
        host.wr(8'h13, 8'hFF);
        `CK("relocked", 16'h0000, irq_active_low)
    endtask
    // verdict and end of run
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_lock();
        t_pin();
        t_rerst();
        give_verdict();
    end
    // watchdog, far beyond the 68 cycles the tests take
    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
